// ===== design/delay_timer.sv
// retriggerable delay timer counting 5 ms ticks
`timescale 1ns/100ps
`default_nettype none
`include "output_delay_consts.svh"

module delay_timer (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_tick,
  input  wire logic                  i_trig,
  input  wire logic [`ODT_DLY_W-1:0] i_delay,
  output logic                       o_done
);

  logic [`ODT_CNT_W-1:0] cnt_r;

  // ----------------------------------------------------------------------------
  // tick counter, cleared whenever the trigger drops
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
    end else if (!i_trig) begin
      cnt_r <= '0;
    end else if (i_tick && cnt_r != `ODT_CNT_MAX) begin
      cnt_r <= cnt_r + 17'h0_0001;
    end
  end

  // first tick may be partial, so one extra tick keeps the delay a true minimum
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_done <= 1'b0;
    end else begin
      o_done <= i_trig && (i_delay == 16'h0000 || cnt_r > {1'b0, i_delay});
    end
  end

endmodule // delay_timer
`default_nettype wire

// ===== design/output_delay_consts.svh
// timing counts, reset values and widths for the output delay timers
`ifndef OUTPUT_DELAY_CONSTS_SVH
`define OUTPUT_DELAY_CONSTS_SVH

// ----------------------------------------------------------------------------
// timebase
// ----------------------------------------------------------------------------
`define ODT_MCLK_PERIOD_NS 32'h0000_0032
`define ODT_TICK_PERIOD_NS 32'h004c_4b40
`define ODT_TICK_CYCLES    (`ODT_TICK_PERIOD_NS / `ODT_MCLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// delay widths and reset values, in 5 ms ticks
// ----------------------------------------------------------------------------
`define ODT_DLY_W          16
`define ODT_CNT_W          17
`define ODT_CNT_MAX        17'h1_ffff
`define ODT_SW_NUM         2
`define ODT_SW_ON_RST      16'h0000
`define ODT_SW_OFF_RST     16'h0000
`define ODT_SW_NT_RST      16'h2ee0
`define ODT_ANA_NT_RST     16'h0000
`define ODT_NOSYNC_RST     16'h0000
`define ODT_TEMP_COMP_RST  1'h1

`endif

// ===== design/output_delay_pkg.sv
// types shared by the output delay timers
`default_nettype none
package output_delay_pkg;

  typedef enum logic [1:0] {
    NT_HOLD,
    NT_ON,
    NT_OFF
  } sw_nt_act_t;

  typedef enum logic [1:0] {
    FB_HOLD,
    FB_HIGH,
    FB_LOW
  } ana_fb_t;

  typedef enum logic [1:0] {
    DRV_TRACK,
    DRV_HOLD,
    DRV_HIGH,
    DRV_LOW
  } ana_drive_t;

  typedef struct packed {
    logic [1:0][15:0] sw_on_dly;
    logic [1:0][15:0] sw_off_dly;
    logic [1:0][15:0] sw_nt_dly;
    sw_nt_act_t [1:0] sw_nt_act;
    logic [15:0]      ana_nt_dly;
    ana_fb_t          cur_fb;
    ana_fb_t          vol_fb;
    logic [15:0]      nosync_dly;
    logic             temp_comp_en;
  } cfg_t;

  typedef struct packed {
    logic       target;
    logic       sync_used;
    logic       sync_ok;
    logic [1:0] want_on;
  } sense_t;

endpackage
`default_nettype wire

// ===== design/output_delay_timers.sv
// output delay timers for the switch and analog outputs
//
// Overview of operation
// - every delay 0 to 5.46 min, 5 ms step
// - each switch has on, off, no-target delays
// - switch on/off default 0, no-target 60 s
// - delay starts at first triggering condition
// - delay clears when trigger goes away early
// - switch changes only after full uninterrupted delay
// - one analog no-target delay, default zero
// - expired analog delay forces high, low or hold
// - separate fallback for current and voltage outputs
// - analog delay starts on loss, clears on return
// - no-sync delay only with sync, default zero
// - temperature compensation selectable, enabled by default
`timescale 1ns/100ps
`default_nettype none
`include "output_delay_consts.svh"

module output_delay_timers #(
  parameter int unsigned TICK_CYCLES = `ODT_TICK_CYCLES
) (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rstn,
  input  wire logic                         i_cfg_wr,
  input  wire output_delay_pkg::cfg_t       i_cfg,
  input  wire output_delay_pkg::sense_t     i_sense,
  output logic [`ODT_SW_NUM-1:0]            o_sw,
  output output_delay_pkg::ana_drive_t      o_cur_drv,
  output output_delay_pkg::ana_drive_t      o_vol_drv,
  output logic                              o_nosync,
  output logic                              o_temp_comp_en,
  output output_delay_pkg::cfg_t            o_cfg
);
  import output_delay_pkg::*;

  logic        rst_meta_r;
  logic        rst_sync_r;
  logic [16:0] div_r;
  logic        tick_r;
  cfg_t        cfg_r;
  logic        ana_done;
  logic        nosync_done;

  // ----------------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------------
  // 5 ms tick divider
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else if (div_r == 17'(TICK_CYCLES - 1)) begin
      div_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 17'h0_0001;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // configuration, loaded whole on a write strobe
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cfg_r.sw_on_dly    <= {`ODT_SW_ON_RST, `ODT_SW_ON_RST};
      cfg_r.sw_off_dly   <= {`ODT_SW_OFF_RST, `ODT_SW_OFF_RST};
      cfg_r.sw_nt_dly    <= {`ODT_SW_NT_RST, `ODT_SW_NT_RST};
      cfg_r.sw_nt_act    <= '{NT_HOLD, NT_HOLD};
      cfg_r.ana_nt_dly   <= `ODT_ANA_NT_RST;
      cfg_r.cur_fb       <= FB_HOLD;
      cfg_r.vol_fb       <= FB_HOLD;
      cfg_r.nosync_dly   <= `ODT_NOSYNC_RST;
      cfg_r.temp_comp_en <= `ODT_TEMP_COMP_RST;
    end else if (i_cfg_wr) begin
      cfg_r <= i_cfg;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_cfg          <= '0;
      o_temp_comp_en <= 1'b0;
    end else begin
      o_cfg          <= cfg_r;
      o_temp_comp_en <= cfg_r.temp_comp_en;
    end
  end

  // ----------------------------------------------------------------------------
  // switch outputs
  // ----------------------------------------------------------------------------
  // triggers are mutually exclusive, so only one timer per switch runs at once
  for (genvar s = 0; s < `ODT_SW_NUM; s++) begin : g_sw
    logic on_trig;
    logic off_trig;
    logic nt_trig;
    logic on_done;
    logic off_done;
    logic nt_done;

    assign on_trig  = i_sense.target && i_sense.want_on[s] && !o_sw[s];
    assign off_trig = i_sense.target && !i_sense.want_on[s] && o_sw[s];
    assign nt_trig  = !i_sense.target;

    delay_timer u_on (
      .i_mclk  (i_mclk),
      .i_rstn  (rst_sync_r),
      .i_tick  (tick_r),
      .i_trig  (on_trig),
      .i_delay (cfg_r.sw_on_dly[s]),
      .o_done  (on_done)
    );

    delay_timer u_off (
      .i_mclk  (i_mclk),
      .i_rstn  (rst_sync_r),
      .i_tick  (tick_r),
      .i_trig  (off_trig),
      .i_delay (cfg_r.sw_off_dly[s]),
      .o_done  (off_done)
    );

    delay_timer u_nt (
      .i_mclk  (i_mclk),
      .i_rstn  (rst_sync_r),
      .i_tick  (tick_r),
      .i_trig  (nt_trig),
      .i_delay (cfg_r.sw_nt_dly[s]),
      .o_done  (nt_done)
    );

    always_ff @(posedge i_mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
        o_sw[s] <= 1'b0;
      end else if (nt_done) begin
        unique case (cfg_r.sw_nt_act[s])
          NT_ON:   o_sw[s] <= 1'b1;
          NT_OFF:  o_sw[s] <= 1'b0;
          default: o_sw[s] <= o_sw[s];
        endcase
      end else if (on_done) begin
        o_sw[s] <= 1'b1;
      end else if (off_done) begin
        o_sw[s] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // analog no-target and no-sync delays
  // ----------------------------------------------------------------------------
  delay_timer u_ana_nt (
    .i_mclk  (i_mclk),
    .i_rstn  (rst_sync_r),
    .i_tick  (tick_r),
    .i_trig  (!i_sense.target),
    .i_delay (cfg_r.ana_nt_dly),
    .o_done  (ana_done)
  );

  delay_timer u_nosync (
    .i_mclk  (i_mclk),
    .i_rstn  (rst_sync_r),
    .i_tick  (tick_r),
    .i_trig  (i_sense.sync_used && !i_sense.sync_ok),
    .i_delay (cfg_r.nosync_dly),
    .o_done  (nosync_done)
  );

  function automatic ana_drive_t fb_drive(input ana_fb_t fb);
    unique case (fb)
      FB_HIGH: fb_drive = DRV_HIGH;
      FB_LOW:  fb_drive = DRV_LOW;
      default: fb_drive = DRV_HOLD;
    endcase
  endfunction

  always_ff @(posedge i_mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_cur_drv <= DRV_TRACK;
      o_vol_drv <= DRV_TRACK;
      o_nosync  <= 1'b0;
    end else begin
      o_cur_drv <= ana_done ? fb_drive(cfg_r.cur_fb) : DRV_TRACK;
      o_vol_drv <= ana_done ? fb_drive(cfg_r.vol_fb) : DRV_TRACK;
      o_nosync  <= nosync_done && i_sense.sync_used;
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rst_sync_r);

  a_tick_period: assert property (tick_r |=> !tick_r)
    else $error("tick pulse longer than one cycle");
  a_sw_on_zero: assert property (
    (cfg_r.sw_on_dly[0] == 16'h0000 && g_sw[0].on_trig && !g_sw[0].nt_done) |-> ##2 o_sw[0])
    else $error("zero on delay did not act at once");
  a_sw_on_held: assert property ($rose(o_sw[0]) |-> $past(g_sw[0].on_done) || $past(g_sw[0].nt_done))
    else $error("switch turned on without expired delay");
  a_sw_off_held: assert property ($fell(o_sw[0]) |-> $past(g_sw[0].off_done) || $past(g_sw[0].nt_done))
    else $error("switch turned off without expired delay");
  a_trig_clear: assert property (!g_sw[0].on_trig |=> g_sw[0].u_on.cnt_r == 17'h0_0000)
    else $error("on delay not cleared");
  a_ana_clear: assert property (i_sense.target |=> ##1 o_cur_drv == DRV_TRACK && o_vol_drv == DRV_TRACK)
    else $error("analog fallback held after target return");
  a_ana_fallback: assert property (ana_done && cfg_r.cur_fb == FB_HIGH |=> o_cur_drv == DRV_HIGH)
    else $error("current fallback not applied");
  a_vol_fallback: assert property (ana_done && cfg_r.vol_fb == FB_LOW |=> o_vol_drv == DRV_LOW)
    else $error("voltage fallback not applied");
  a_nosync_gate: assert property (!i_sense.sync_used |=> !o_nosync)
    else $error("no-sync flagged without sync in use");
  a_nt_start: assert property (!i_sense.target && tick_r && u_ana_nt.cnt_r == 17'h0_0000
    |=> u_ana_nt.cnt_r == 17'h0_0001)
    else $error("no-target delay did not start");
  // readback flop resets to 0 while the config resets to 1, so skip the release edge
  a_temp_comp: assert property ($past(rst_sync_r) |-> o_temp_comp_en == $past(cfg_r.temp_comp_en))
    else $error("temperature compensation output stale");

  c_sw_on: cover property ($rose(o_sw[0]));
  c_sw_off: cover property ($fell(o_sw[1]));
  c_ana_fb: cover property (o_cur_drv == DRV_LOW);
  c_nosync: cover property ($rose(o_nosync));

endmodule // output_delay_timers
`default_nettype wire

// ===== test/output_delay_timers_test.sv
// self-checking bench for the output delay timers
`timescale 1ns/100ps
`default_nettype none

module output_delay_timers_test;
  import output_delay_pkg::*;

  // --------------------------------------------------------------------------
  // signals and design
  // --------------------------------------------------------------------------
  localparam int TK = 4;  // short tick so whole delays fit in a few cycles

  logic       i_mclk;
  logic       i_rstn;
  logic       i_cfg_wr;
  cfg_t       i_cfg;
  cfg_t       o_cfg;
  cfg_t       c;
  sense_t     i_sense;
  logic [1:0] o_sw;
  ana_drive_t o_cur_drv;
  ana_drive_t o_vol_drv;
  logic       o_nosync;
  logic       o_temp_comp_en;
  int         n_errors;
  int         checks_done;
  int         n;

  output_delay_timers #(.TICK_CYCLES(TK)) dut (
    .i_mclk         (i_mclk),
    .i_rstn         (i_rstn),
    .i_cfg_wr       (i_cfg_wr),
    .i_cfg          (i_cfg),
    .i_sense        (i_sense),
    .o_sw           (o_sw),
    .o_cur_drv      (o_cur_drv),
    .o_vol_drv      (o_vol_drv),
    .o_nosync       (o_nosync),
    .o_temp_comp_en (o_temp_comp_en),
    .o_cfg          (o_cfg)
  );

  initial begin
    i_mclk = 1'h0;
    forever #25 i_mclk = ~i_mclk;
  end

  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(negedge i_mclk);
  endtask

  // one-cycle load pulse, then wait until the readback has landed
  task automatic write_cfg(input cfg_t v);
    i_cfg    = v;
    i_cfg_wr = 1'h1;
    step(1);
    i_cfg_wr = 1'h0;
    step(2);
  endtask

  // counts falling edges until the chosen output shows v; bounded
  task automatic measure(input int sel, input logic [1:0] v, output int k);
    logic [1:0] seen;
    k    = 0;
    seen = ~v;
    while (seen !== v) begin
      step(1);
      k++;
      case (sel)
        0:       seen = o_sw;
        1:       seen = o_cur_drv;
        2:       seen = o_vol_drv;
        default: seen = {1'h0, o_nosync};
      endcase
      if (seen !== v && k >= 400) begin
        n_errors++;
        $display("CHECK FAILED wait on output %0d expected %h seen %h", sel, v, seen);
        finish_test();
      end
    end
  endtask

  task automatic in_range(input string what, input int k, input int lo, input int hi);
    check(what, (k >= lo && k <= hi), 1'h1);
  endtask

  // no-target delays parked at the maximum so switches stay put
  function automatic cfg_t base();
    cfg_t b;
    b = '0;
    b.sw_nt_dly[0] = 16'hffff;
    b.sw_nt_dly[1] = 16'hffff;
    b.temp_comp_en = 1'h1;
    return b;
  endfunction

  function automatic logic [1:0] exp_drv(input int fb);
    case (fb)
      0:       return DRV_HOLD;
      1:       return DRV_HIGH;
      default: return DRV_LOW;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  initial begin
    i_rstn      = 1'h0;
    i_cfg_wr    = 1'h0;
    i_cfg       = '0;
    i_sense     = '0;
    n_errors    = 0;
    checks_done = 0;
    step(8);
    i_rstn = 1'h1;
    step(4);
    // 60 s is 12000 ticks of 5 ms
    c              = '0;
    c.sw_nt_dly[0] = 16'h2ee0;
    c.sw_nt_dly[1] = 16'h2ee0;
    c.temp_comp_en = 1'h1;
    check("reset config", o_cfg, c);
    check("reset temp comp", o_temp_comp_en, 1'h1);
    check("reset current drive", o_cur_drv, DRV_HOLD);
    $display("test reset done");

    c               = base();
    c.sw_on_dly[1]  = 16'hffff;
    c.sw_off_dly[0] = 16'h1234;
    c.ana_nt_dly    = 16'h00a5;
    c.cur_fb        = FB_HIGH;
    c.vol_fb        = FB_LOW;
    c.nosync_dly    = 16'h0001;
    c.temp_comp_en  = 1'h0;
    c.sw_nt_act[1]  = NT_ON;
    write_cfg(c);
    check("config readback", o_cfg, c);
    check("temp comp off", o_temp_comp_en, 1'h0);
    $display("test config done");

    // zero delays: trigger sampled on one edge, switch moves on the next
    write_cfg(base());
    i_sense.target  = 1'h1;
    i_sense.want_on = 2'h3;
    measure(0, 2'h3, n);
    check("on latency zero", n, 2);
    i_sense.want_on = 2'h0;
    measure(0, 2'h0, n);
    check("off latency zero", n, 2);
    c               = base();
    c.sw_on_dly[0]  = 16'h0003;
    c.sw_off_dly[1] = 16'h0002;
    write_cfg(c);
    i_sense.want_on = 2'h1;
    step(8);
    check("on held early", o_sw, 2'h0);
    i_sense.want_on = 2'h0;
    step(2);
    i_sense.want_on = 2'h1;
    measure(0, 2'h1, n);
    in_range("on retrigger", n, 13, 20);
    i_sense.want_on = 2'h3;
    measure(0, 2'h3, n);
    check("switch two on", n, 2);
    i_sense.want_on = 2'h1;
    measure(0, 2'h1, n);
    in_range("off delay", n, 9, 16);
    c              = base();
    c.sw_nt_dly[0] = 16'h0001;
    c.sw_nt_dly[1] = 16'h0001;
    c.sw_nt_act[0] = NT_OFF;
    c.sw_nt_act[1] = NT_ON;
    write_cfg(c);
    i_sense.target = 1'h0;
    measure(0, 2'h2, n);
    in_range("no target switch", n, 5, 12);
    // expired no-target delay with hold action must leave both switches where they are
    c              = base();
    c.sw_nt_dly[0] = 16'h0001;
    c.sw_nt_dly[1] = 16'h0001;
    write_cfg(c);
    step(12);
    check("no target hold", o_sw, 2'h2);
    $display("test switches done");

    i_sense.target = 1'h1;
    c              = base();
    c.ana_nt_dly   = 16'h0002;
    c.cur_fb       = FB_HIGH;
    c.vol_fb       = FB_LOW;
    write_cfg(c);
    i_sense.target = 1'h0;
    step(5);
    i_sense.target = 1'h1;
    step(3);
    check("analog retrigger", o_cur_drv, DRV_TRACK);
    i_sense.target = 1'h0;
    measure(1, DRV_HIGH, n);
    in_range("current fallback", n, 9, 16);
    check("voltage fallback", o_vol_drv, DRV_LOW);
    i_sense.target = 1'h1;
    measure(1, DRV_TRACK, n);
    check("analog return", n, 2);
    for (int i = 0; i < 3; i++) begin
      c        = base();
      c.cur_fb = ana_fb_t'(i);
      c.vol_fb = ana_fb_t'((i + 1) % 3);
      write_cfg(c);
      i_sense.target = 1'h0;
      step(3);
      check("current select", o_cur_drv, exp_drv(i));
      check("voltage select", o_vol_drv, exp_drv((i + 1) % 3));
      i_sense.target = 1'h1;
      step(3);
    end
    $display("test analog done");

    c            = base();
    c.nosync_dly = 16'h0001;
    write_cfg(c);
    step(12);
    check("no sync unused", o_nosync, 1'h0);
    i_sense.sync_used = 1'h1;
    measure(3, 2'h1, n);
    in_range("no sync delay", n, 5, 12);
    i_sense.sync_ok = 1'h1;
    step(3);
    check("sync restored", o_nosync, 1'h0);
    $display("test no sync done");
    finish_test();
  end
endmodule // output_delay_timers_test

`default_nettype wire
